// ---- logic/mps_channel.sv ----
// Purpose: One PWM channel with one rise per interval
// Assumes: Comparator inputs synchronous to clk
// Notes:   Excluded channels stay low even during a trip
`timescale 1ns/1ps
`include "mps_map.svh"
module mps_channel
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic active,
  input  wire logic windowStart,
  input  wire logic rampCross,
  input  wire logic forceOn,
  output logic      pwmOut,
  output logic      pulseEnd
);
  mps_pkg::mps_ch_state_t state;
  mps_pkg::mps_ch_state_t next_state;

  wire logic rise = (state == mps_pkg::MPS_CH_IDLE) && (rampCross || forceOn);
  wire logic fall = (state == mps_pkg::MPS_CH_HIGH) && rampCross && !forceOn;

  always_comb
  begin
    next_state = state;
    unique case (state)
      mps_pkg::MPS_CH_IDLE:
        if (rise) next_state = mps_pkg::MPS_CH_HIGH;
      mps_pkg::MPS_CH_HIGH:
        if (fall) next_state = mps_pkg::MPS_CH_SPENT;
      mps_pkg::MPS_CH_SPENT:
        next_state = mps_pkg::MPS_CH_SPENT;
      default:
        next_state = mps_pkg::MPS_CH_IDLE;
    endcase
    // New interval rearms; a pulse still high carries over
    if (windowStart && next_state == mps_pkg::MPS_CH_SPENT)
      next_state = mps_pkg::MPS_CH_IDLE;
    if (!active)
      next_state = mps_pkg::MPS_CH_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state    <= mps_pkg::MPS_CH_IDLE;
      pwmOut   <= 1'b0;
      pulseEnd <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      pwmOut   <= (next_state == mps_pkg::MPS_CH_HIGH);
      pulseEnd <= active && fall;
    end
  end
endmodule

// ---- logic/mps_map.svh ----
// Purpose: Named constants for the multiphase PWM sequencer
// Assumes: 200 MHz system clock
// Notes:   Clock period in ns; period values given directly in clock cycles
`ifndef MPS_MAP_SVH
`define MPS_MAP_SVH

`define MPS_CLK_PERIOD_NS   5
`define MPS_PERIOD_DEF      16'd1000
`define MPS_PERIOD_MIN      16'd12
`define MPS_CH_MAX          4
`define MPS_PHASE_CNT_W     16

`endif

// ---- logic/mps_pkg.sv ----
// Purpose: Types for the multiphase PWM sequencer
// Assumes: Nothing beyond the map header
// Notes:   Phase count mode encoding
package mps_pkg;
  typedef enum logic [1:0] {
    MPS_MODE_FOUR  = 2'b00,
    MPS_MODE_THREE = 2'b01,
    MPS_MODE_TWO   = 2'b10
  } mps_mode_t;

  typedef enum logic [1:0] {
    MPS_CH_IDLE  = 2'b00,
    MPS_CH_HIGH  = 2'b01,
    MPS_CH_SPENT = 2'b10
  } mps_ch_state_t;
endpackage

// ---- logic/mps_sequencer.sv ----
// Purpose: Multiphase PWM sequencer top
// Assumes: Comparator and sense-tie inputs are synchronous digital levels
// Notes:   Analog ramp, error amp and current maths are outside
// Function
// - Interval clock period is programmed switching period
// - Rise allowed anywhere within the interval
// - Low while error below ramp
// - Ramp crossing drives output high
// - Second crossing ends the pulse
// - One rise per channel per interval
// - Alignment trip forces active channels on unless already spent this interval
// - Cycle spans successive pulse terminations
// - Four phases fire 4-3-2-1, quarter spaced
// - Ch4 sense tied: three phases, third spaced
// - Ch3 sense tied: two phases, half spaced
// - Sample every active channel current each cycle
`timescale 1ns/1ps
`include "mps_map.svh"
module mps_sequencer
#(
  parameter int CH = `MPS_CH_MAX
)
(
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic [`MPS_PHASE_CNT_W-1:0]   freqSetPeriod,
  input  wire logic [CH-1:0]                 rampCross,
  input  wire logic                          phaseAlignTrip,
  input  wire logic                          senseCh3Neg,
  input  wire logic                          senseCh4Neg,
  output logic      [CH-1:0]                 phaseOut,
  output logic      [CH-1:0]                 currentSample,
  output logic      [CH-1:0]                 cycleDone,
  output logic      [1:0]                    phaseMode
);
  // Period latched from the frequency-set input; clamped so phases stay distinct
  logic [`MPS_PHASE_CNT_W-1:0] period;
  logic [`MPS_PHASE_CNT_W-1:0] tick;
  mps_pkg::mps_mode_t          mode;

  wire logic [`MPS_PHASE_CNT_W-1:0] periodIn =
    (freqSetPeriod < `MPS_PERIOD_MIN) ? `MPS_PERIOD_MIN : freqSetPeriod;

  // Ch3 tie wins over ch4 tie since two-phase needs ch3 unused too
  wire mps_pkg::mps_mode_t next_mode =
    senseCh3Neg ? mps_pkg::MPS_MODE_TWO :
    senseCh4Neg ? mps_pkg::MPS_MODE_THREE :
                  mps_pkg::MPS_MODE_FOUR;

  wire logic [2:0] nPhases =
    (mode == mps_pkg::MPS_MODE_TWO)   ? 3'd2 :
    (mode == mps_pkg::MPS_MODE_THREE) ? 3'd3 : 3'd4;

  wire logic periodEnd = (tick >= period - 16'h0001);
  wire logic [`MPS_PHASE_CNT_W-1:0] next_tick = periodEnd ? 16'h0000 : tick + 16'h0001;

  // Slot boundaries: k*period/n for the current channel count
  wire logic [`MPS_PHASE_CNT_W+1:0] tickScaled = {2'b00, tick} * 18'(nPhases);
  wire logic [CH-1:0] activeMask;
  wire logic [CH-1:0] windowStart;

  genvar g;
  generate
    for (g = 0; g < CH; g++)
    begin : gCh
      // Firing slot: highest channel first, ch1 last
      wire logic [2:0] slot = 3'(nPhases - 3'(g) - 3'd1);
      wire logic [`MPS_PHASE_CNT_W+1:0] target = 18'(slot) * {2'b00, period};
      assign activeMask[g] = (3'(g) < nPhases);
      assign windowStart[g] = activeMask[g] &&
        (tickScaled >= target) && (tickScaled < target + 18'(nPhases));

      mps_channel uChannel
      (
        .clk         (clk),
        .rst_n       (rst_n),
        .active      (activeMask[g]),
        .windowStart (windowStart[g]),
        .rampCross   (rampCross[g]),
        .forceOn     (phaseAlignTrip && activeMask[g]),
        .pwmOut      (phaseOut[g]),
        .pulseEnd    (cycleDone[g])
      );
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      period        <= `MPS_PERIOD_DEF;
      tick          <= 16'h0000;
      mode          <= mps_pkg::MPS_MODE_FOUR;
      currentSample <= '0;
      phaseMode     <= 2'b00;
    end
    else
    begin
      tick          <= next_tick;
      if (periodEnd)
      begin
        period <= periodIn;
        mode   <= next_mode;
      end
      currentSample <= activeMask;
      phaseMode     <= mode;
    end
  end
endmodule

// ---- sim/mps_checker.sv ----
// Purpose: Port checks for mps_sequencer
// Assumes: Four channels
// Notes:   Bound below
`timescale 1ns/1ps
module mps_checker
#(
  parameter int CH = 4
)
(
  input wire logic          clk,
  input wire logic          rst_n,
  input wire logic [15:0]   freqSetPeriod,
  input wire logic [CH-1:0] rampCross,
  input wire logic          phaseAlignTrip,
  input wire logic          senseCh3Neg,
  input wire logic          senseCh4Neg,
  input wire logic [CH-1:0] phaseOut,
  input wire logic [CH-1:0] currentSample,
  input wire logic [CH-1:0] cycleDone,
  input wire logic [1:0]    phaseMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rise_cause_a: assert property ($rose(phaseOut[0]) |-> $past(rampCross[0] | phaseAlignTrip)) else $error("rise");
  fall_cause_a: assert property ($fell(phaseOut[0]) |-> $past(rampCross[0]) && !$past(phaseAlignTrip)) else $error("fall");
  trip_hold_a: assert property (phaseAlignTrip |=> (phaseOut & $past(phaseOut)) == $past(phaseOut)) else $error("trip");
  fall_done_a: assert property ($fell(phaseOut[1]) |-> cycleDone[1]) else $error("done");
  done_pulse_a: assert property (cycleDone[2] |=> !cycleDone[2]) else $error("pulse");
  two_off_a: assert property (phaseMode == 2'h2 |-> phaseOut[3:2] == 2'h0) else $error("two");
  three_off_a: assert property (phaseMode == 2'h1 |-> !phaseOut[3]) else $error("three");
  sample_all_a: assert property (phaseMode == 2'h0 && $past(phaseMode) == 2'h0 && $past(rst_n) |-> currentSample == 4'hf)
    else $error("sample");
endmodule

bind mps_sequencer mps_checker #(.CH(CH)) chk (.*);

// ---- sim/mps_gate_model.sv ----
// Purpose: Gate driver of each phase
// Assumes: No dead time modelled
// Notes:   Level in, switch states out
`timescale 1ns/1ps
module mps_gate_model
(
  input wire logic [3:0] phaseOut,
  output logic     [3:0] upperOn,
  output logic     [3:0] lowerOn
);
  assign upperOn = phaseOut;
  assign lowerOn = ~phaseOut;
endmodule

// ---- sim/testbench.sv ----
// Purpose: Self-checking bench for mps_sequencer
// Assumes: Period 1000 until first wrap
// Notes:   Trip used to reveal active channels
`timescale 1ns/1ps
module testbench;
  logic        clk = 0, rst_n = 0, phaseAlignTrip = 0, senseCh3Neg = 0, senseCh4Neg = 0;
  logic [15:0] freqSetPeriod = 16'h03e8;
  logic [3:0]  rampCross = 4'h0, phaseOut, currentSample, cycleDone, upperOn, lowerOn;
  logic [1:0]  phaseMode;
  int          errors = 0, checked = 0;
  mps_sequencer dut (.clk, .rst_n, .freqSetPeriod, .rampCross, .phaseAlignTrip, .senseCh3Neg, .senseCh4Neg,
    .phaseOut, .currentSample, .cycleDone, .phaseMode);
  mps_gate_model drv (.phaseOut, .upperOn, .lowerOn);
  initial forever #2.5 clk = ~clk;
  task report_and_stop;
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task cmp(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task drive(input logic [3:0] v);
    @(posedge clk) rampCross <= v;
  endtask
  task pulse_once;
    drive(4'h1);
    #1 cmp(currentSample, 4'hf);
    drive(4'h0);
    #1 cmp(phaseOut, 4'h1);
    cmp(upperOn, 4'h1);
    cmp(lowerOn, 4'he);
    drive(4'h1);
    drive(4'h0);
    #1 cmp(phaseOut, 4'h0);
    cmp(cycleDone, 4'h1);
    drive(4'h1);
    #1 cmp(cycleDone, 4'h0);
    drive(4'h0);
    #1 cmp(phaseOut, 4'h0);
  endtask
  task trip_all;
    @(posedge clk) phaseAlignTrip <= 1;
    @(posedge clk) phaseAlignTrip <= 0;
    #1 cmp(phaseOut, 4'he);
    drive(4'he);
    drive(4'h0);
    #1 cmp(cycleDone, 4'he);
  endtask
  task mode_check(input logic t3, input logic t4, input logic [1:0] m, input logic [3:0] act);
    @(posedge clk) senseCh3Neg <= t3;
    senseCh4Neg <= t4;
    freqSetPeriod <= 16'h000c;
    repeat (1010) @(posedge clk);
    phaseAlignTrip <= 1;
    repeat (20) @(posedge clk);
    #1 cmp({2'h0, phaseMode}, {2'h0, m});
    cmp(phaseOut, act);
    cmp(currentSample, act);
    @(posedge clk) phaseAlignTrip <= 0;
    drive(4'hf);
    drive(4'h0);
  endtask
  // Comparator stuck high: each active channel pulses once per window, so the
  // termination pulses show the firing order and the slot spacing
  task order_check(input logic [3:0] first, input int gap);
    int         n;
    logic [3:0] want;
    n = 0;
    want = first;
    drive(4'hf);
    repeat (24) @(posedge clk);
    #1;
    while (cycleDone !== first && n < 24)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (want != 4'h0)
    begin
      cmp(cycleDone, want);
      repeat (gap) @(posedge clk);
      #1;
      want = want >> 1;
    end
    drive(4'h0);
  endtask
  initial
  begin
    #40000;
    errors++;
    report_and_stop;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    pulse_once;
    trip_all;
    mode_check(1'b1, 1'b0, 2'h2, 4'h3);
    order_check(4'h2, 6);
    mode_check(1'b1, 1'b1, 2'h2, 4'h3);
    mode_check(1'b0, 1'b1, 2'h1, 4'h7);
    order_check(4'h4, 4);
    mode_check(1'b0, 1'b0, 2'h0, 4'hf);
    order_check(4'h8, 3);
    report_and_stop;
  end
endmodule
